// ### rtl/aodr_esd_counter.sv
// saturating counter of esd events
module aodr_esd_counter #(
    parameter int WIDTH = aodr_pkg::ESD_W
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // event in
    input wire logic esd_event,
    // count and events out
    output logic [WIDTH-1:0] count,
    output logic counted,
    output logic saturated_hit
);
    localparam logic [WIDTH-1:0] CNT_MAX = {WIDTH{1'b1}};

    if (WIDTH < 1 || WIDTH > aodr_pkg::ESD_W) begin : g_chk
        $error("esd counter width must be 1 to 6");
    end

    logic [WIDTH-1:0] count_reg;
    logic [WIDTH-1:0] count_next;
    logic counted_reg;
    logic counted_next;
    logic sat_reg;
    logic sat_next;

    always_comb begin
        count_next = count_reg;
        counted_next = 1'b0;
        sat_next = 1'b0;
        if (esd_event && count_reg != CNT_MAX) begin
            count_next = count_reg + 1'b1;
            counted_next = 1'b1;
            sat_next = (count_next == CNT_MAX);
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            count_reg <= '0;
            counted_reg <= 1'b0;
            sat_reg <= 1'b0;
        end else begin
            count_reg <= count_next;
            counted_reg <= counted_next;
            sat_reg <= sat_next;
        end
    end

    assign count = count_reg;
    assign counted = counted_reg;
    assign saturated_hit = sat_reg;
endmodule : aodr_esd_counter

// ### rtl/aodr_irq.sv
// sticky interrupt status with mask and level output
module aodr_irq #(
    parameter int N = aodr_pkg::IRQ_N
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // events, software clear and mask
    input wire logic [N-1:0] set,
    input wire logic [N-1:0] clear,
    input wire logic [N-1:0] mask,
    // status and interrupt
    output logic [N-1:0] status,
    output logic irq
);
    if (N < 1 || N > 16) begin : g_chk
        $error("interrupt count must be 1 to 16");
    end

    logic [N-1:0] stat_reg;
    logic [N-1:0] stat_next;
    logic irq_reg;
    logic irq_next;

    for (genvar i = 0; i < N; i++) begin : g_bit
        // set wins over a clear in the same cycle
        always_comb begin
            stat_next[i] = set[i] | (stat_reg[i] & ~clear[i]);
        end
    end

    always_comb begin
        irq_next = |(stat_next & mask);
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            stat_reg <= '0;
            irq_reg <= 1'b0;
        end else begin
            stat_reg <= stat_next;
            irq_reg <= irq_next;
        end
    end

    assign status = stat_reg;
    assign irq = irq_reg;
endmodule : aodr_irq

// ### rtl/aodr_pkg.sv
// constants and types for the analog override and delay register bank
package aodr_pkg;
    // register indices, byte address is four times the index
    localparam logic [15:0] IDX_FORCE_CTRL = 16'h041e;
    localparam logic [15:0] IDX_OVR = 16'h042f;
    localparam logic [15:0] IDX_DLY = 16'h0430;
    localparam logic [15:0] IDX_ESD = 16'h0442;
    localparam logic [15:0] IDX_IRQ_STAT = 16'h0480;
    localparam logic [15:0] IDX_IRQ_MASK = 16'h0481;
    // field positions
    localparam int FORCE_EN_BIT = 8;
    localparam int OVR_ELOST_BIT = 2;
    localparam int OVR_EDET_BIT = 1;
    localparam int OVR_SLEEP_BIT = 0;
    localparam int TX_LSB = 8;
    localparam int RX_LSB = 4;
    localparam int CODE_W = 4;
    localparam int ESD_LSB = 9;
    localparam int ESD_W = 6;
    localparam int IRQ_ESD_BIT = 0;
    localparam int IRQ_SAT_BIT = 1;
    localparam int IRQ_N = 2;
    // reset values
    localparam logic [15:0] FORCE_CTRL_RST = 16'h0000;
    localparam logic [15:0] OVR_RST = 16'h0000;
    localparam logic [15:0] DLY_RST = 16'h0960;
    localparam logic [15:0] ESD_RST = 16'h0000;
    localparam logic [15:0] IRQ_MASK_RST = 16'h0000;
    // writable bits of each register
    localparam logic [15:0] FORCE_CTRL_WMASK = 16'h0100;
    localparam logic [15:0] OVR_WMASK = 16'h0007;
    localparam logic [15:0] DLY_WMASK = 16'h0ff0;
    localparam logic [15:0] IRQ_WMASK = 16'h0003;
    // bus transfer phase
    typedef enum logic [1:0] {
        AODR_IDLE = 2'b01,
        AODR_ACCESS = 2'b10
    } aodr_phase_t;
endpackage : aodr_pkg

// ### rtl/aodr_regs.sv
// apb register bank for analog front-end overrides, clock delay codes and esd count
module aodr_regs #(
    parameter int ADDR_W = 16,
    parameter int ESD_CNT_W = aodr_pkg::ESD_W
) (
    // clock and reset
    input wire logic SYS_CLK,
    input wire logic RST,
    // apb slave
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [ADDR_W-1:0] PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic [3:0] PSTRB,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    // internally generated front-end controls
    input wire logic INT_SLEEP_EN,
    input wire logic INT_ENERGY_DET_EN,
    input wire logic INT_ENERGY_LOST,
    // controls to the analog front end
    output logic AFE_SLEEP_EN,
    output logic AFE_ENERGY_DET_EN,
    output logic AFE_ENERGY_LOST,
    // clock delay line codes
    output logic [3:0] TX_CLOCK_DELAY_CODE,
    output logic [3:0] RX_CLOCK_DELAY_CODE,
    // esd detector
    input wire logic ESD_EVENT,
    // interrupt
    output logic IRQ
);
    // highest index needs 13 address bits
    if (ADDR_W < 13 || ADDR_W > 32) begin : g_chk
        $error("address width must be 13 to 32");
    end

    // true when the byte address selects the register of this index
    function automatic logic reg_hit(
        input logic [ADDR_W-1:0] addr,
        input logic [15:0] idx
    );
        logic [31:0] full;
        full = 32'(addr);
        reg_hit = (full == {14'h0000, idx, 2'b00});
    endfunction : reg_hit

    // byte-lane merge keeping read-only bits unchanged
    function automatic logic [15:0] lane_merge(
        input logic [15:0] old,
        input logic [31:0] wdata,
        input logic [3:0] strb,
        input logic [15:0] wmask
    );
        logic [15:0] lanes;
        lanes = {{8{strb[1]}}, {8{strb[0]}}};
        lane_merge = (old & ~(lanes & wmask)) | (wdata[15:0] & lanes & wmask);
    endfunction : lane_merge

    // bus phase state
    aodr_pkg::aodr_phase_t phase_reg;
    aodr_pkg::aodr_phase_t phase_next;
    logic pready_reg;
    logic pready_next;
    logic pslverr_reg;
    logic pslverr_next;
    logic [31:0] prdata_reg;
    logic [31:0] prdata_next;

    // software registers
    logic [15:0] force_ctrl_reg;
    logic [15:0] force_ctrl_next;
    logic [15:0] ovr_reg;
    logic [15:0] ovr_next;
    logic [15:0] dly_reg;
    logic [15:0] dly_next;
    logic [15:0] irq_mask_reg;
    logic [15:0] irq_mask_next;

    // front-end drive
    logic afe_sleep_reg;
    logic afe_sleep_next;
    logic afe_edet_reg;
    logic afe_edet_next;
    logic afe_elost_reg;
    logic afe_elost_next;

    // decode
    logic hit_force;
    logic hit_ovr;
    logic hit_dly;
    logic hit_esd;
    logic hit_stat;
    logic hit_mask;
    logic mapped;
    logic wr_commit;

    // counter and interrupt links
    logic [ESD_CNT_W-1:0] esd_count;
    logic esd_counted;
    logic esd_sat_hit;
    logic [15:0] esd_word;
    logic [aodr_pkg::IRQ_N-1:0] irq_set;
    logic [aodr_pkg::IRQ_N-1:0] irq_clear;
    logic [aodr_pkg::IRQ_N-1:0] irq_status;
    logic [15:0] stat_word;

    aodr_esd_counter #(
        .WIDTH(ESD_CNT_W)
    ) u_esd (
        .clk(SYS_CLK),
        .rst(RST),
        .esd_event(ESD_EVENT),
        .count(esd_count),
        .counted(esd_counted),
        .saturated_hit(esd_sat_hit)
    );

    aodr_irq #(
        .N(aodr_pkg::IRQ_N)
    ) u_irq (
        .clk(SYS_CLK),
        .rst(RST),
        .set(irq_set),
        .clear(irq_clear),
        .mask(irq_mask_reg[aodr_pkg::IRQ_N-1:0]),
        .status(irq_status),
        .irq(IRQ)
    );

    // address decode, shared by setup and access phases
    always_comb begin
        hit_force = reg_hit(PADDR, aodr_pkg::IDX_FORCE_CTRL);
        hit_ovr = reg_hit(PADDR, aodr_pkg::IDX_OVR);
        hit_dly = reg_hit(PADDR, aodr_pkg::IDX_DLY);
        hit_esd = reg_hit(PADDR, aodr_pkg::IDX_ESD);
        hit_stat = reg_hit(PADDR, aodr_pkg::IDX_IRQ_STAT);
        hit_mask = reg_hit(PADDR, aodr_pkg::IDX_IRQ_MASK);
        mapped = hit_force | hit_ovr | hit_dly | hit_esd | hit_stat | hit_mask;
        // writes land only at the edge that completes the access
        wr_commit = PSEL & PENABLE & PWRITE & pready_reg & ~pslverr_reg;
    end

    // read words built from live state
    always_comb begin
        esd_word = aodr_pkg::ESD_RST | (16'(esd_count) << aodr_pkg::ESD_LSB);
        stat_word = 16'(irq_status);
        irq_set = '0;
        irq_set[aodr_pkg::IRQ_ESD_BIT] = esd_counted;
        irq_set[aodr_pkg::IRQ_SAT_BIT] = esd_sat_hit;
        irq_clear = '0;
        if (wr_commit && hit_stat) begin
            irq_clear = PWDATA[aodr_pkg::IRQ_N-1:0] & {{(aodr_pkg::IRQ_N-1){PSTRB[0]}}, PSTRB[0]};
        end
    end

    // bus phase and answer
    always_comb begin
        phase_next = phase_reg;
        pready_next = 1'b0;
        pslverr_next = 1'b0;
        prdata_next = prdata_reg;
        case (phase_reg)
            aodr_pkg::AODR_IDLE: begin
                if (PSEL && !PENABLE) begin
                    phase_next = aodr_pkg::AODR_ACCESS;
                    pready_next = 1'b1;
                    pslverr_next = ~mapped;
                    prdata_next = 32'h0000_0000;
                    if (!PWRITE) begin
                        if (hit_force) begin
                            prdata_next[15:0] = force_ctrl_reg & aodr_pkg::FORCE_CTRL_WMASK;
                        end else if (hit_ovr) begin
                            prdata_next[15:0] = ovr_reg & aodr_pkg::OVR_WMASK;
                        end else if (hit_dly) begin
                            prdata_next[15:0] = dly_reg & aodr_pkg::DLY_WMASK;
                        end else if (hit_esd) begin
                            prdata_next[15:0] = esd_word;
                        end else if (hit_stat) begin
                            prdata_next[15:0] = stat_word;
                        end else if (hit_mask) begin
                            prdata_next[15:0] = irq_mask_reg & aodr_pkg::IRQ_WMASK;
                        end
                    end
                end
            end
            aodr_pkg::AODR_ACCESS: begin
                phase_next = aodr_pkg::AODR_IDLE;
            end
            default: begin
                phase_next = aodr_pkg::AODR_IDLE;
            end
        endcase
    end

    // register writes
    always_comb begin
        force_ctrl_next = force_ctrl_reg;
        ovr_next = ovr_reg;
        dly_next = dly_reg;
        irq_mask_next = irq_mask_reg;
        if (wr_commit) begin
            if (hit_force) begin
                force_ctrl_next = lane_merge(force_ctrl_reg, PWDATA, PSTRB,
                    aodr_pkg::FORCE_CTRL_WMASK);
            end
            if (hit_ovr) begin
                ovr_next = lane_merge(ovr_reg, PWDATA, PSTRB, aodr_pkg::OVR_WMASK);
            end
            if (hit_dly) begin
                dly_next = lane_merge(dly_reg, PWDATA, PSTRB, aodr_pkg::DLY_WMASK);
            end
            if (hit_mask) begin
                irq_mask_next = lane_merge(irq_mask_reg, PWDATA, PSTRB, aodr_pkg::IRQ_WMASK);
            end
            // esd status has no write path
        end
    end

    // front-end selection
    always_comb begin
        if (force_ctrl_reg[aodr_pkg::FORCE_EN_BIT]) begin
            afe_sleep_next = ovr_reg[aodr_pkg::OVR_SLEEP_BIT];
            afe_edet_next = ovr_reg[aodr_pkg::OVR_EDET_BIT];
            afe_elost_next = ovr_reg[aodr_pkg::OVR_ELOST_BIT];
        end else begin
            afe_sleep_next = INT_SLEEP_EN;
            afe_edet_next = INT_ENERGY_DET_EN;
            afe_elost_next = INT_ENERGY_LOST;
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            phase_reg <= aodr_pkg::AODR_IDLE;
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg <= 32'h0000_0000;
            force_ctrl_reg <= aodr_pkg::FORCE_CTRL_RST;
            ovr_reg <= aodr_pkg::OVR_RST;
            dly_reg <= aodr_pkg::DLY_RST;
            irq_mask_reg <= aodr_pkg::IRQ_MASK_RST;
            afe_sleep_reg <= 1'b0;
            afe_edet_reg <= 1'b0;
            afe_elost_reg <= 1'b0;
        end else begin
            phase_reg <= phase_next;
            pready_reg <= pready_next;
            pslverr_reg <= pslverr_next;
            prdata_reg <= prdata_next;
            force_ctrl_reg <= force_ctrl_next;
            ovr_reg <= ovr_next;
            dly_reg <= dly_next;
            irq_mask_reg <= irq_mask_next;
            afe_sleep_reg <= afe_sleep_next;
            afe_edet_reg <= afe_edet_next;
            afe_elost_reg <= afe_elost_next;
        end
    end

    assign PRDATA = prdata_reg;
    assign PREADY = pready_reg;
    assign PSLVERR = pslverr_reg;
    assign AFE_SLEEP_EN = afe_sleep_reg;
    assign AFE_ENERGY_DET_EN = afe_edet_reg;
    assign AFE_ENERGY_LOST = afe_elost_reg;
    assign TX_CLOCK_DELAY_CODE = dly_reg[aodr_pkg::TX_LSB +: aodr_pkg::CODE_W];
    assign RX_CLOCK_DELAY_CODE = dly_reg[aodr_pkg::RX_LSB +: aodr_pkg::CODE_W];
endmodule : aodr_regs

// ### test/aodr_chk.sv
// port assertions for the override and delay register bank
module aodr_chk #(
    parameter int ADDR_W = 16,
    parameter int ESD_CNT_W = 6
) (
    // clock and reset
    input wire logic SYS_CLK,
    input wire logic RST,
    // apb
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [ADDR_W-1:0] PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic [3:0] PSTRB,
    input wire logic [31:0] PRDATA,
    input wire logic PREADY,
    input wire logic PSLVERR,
    // front end
    input wire logic INT_SLEEP_EN,
    input wire logic INT_ENERGY_DET_EN,
    input wire logic INT_ENERGY_LOST,
    input wire logic AFE_SLEEP_EN,
    input wire logic AFE_ENERGY_DET_EN,
    input wire logic AFE_ENERGY_LOST,
    input wire logic [3:0] TX_CLOCK_DELAY_CODE,
    input wire logic [3:0] RX_CLOCK_DELAY_CODE,
    input wire logic IRQ
);
    logic force_reg;
    logic [2:0] ovr_reg;
    wire logic acc = PSEL && PENABLE && PREADY && PWRITE;
    wire logic dly_hit = PADDR == ADDR_W'(16'h10c0);
    wire logic [2:0] sel = force_reg ? ovr_reg
        : {INT_ENERGY_LOST, INT_ENERGY_DET_EN, INT_SLEEP_EN};
    wire logic mapped = PADDR inside {ADDR_W'(16'h1078), ADDR_W'(16'h10bc), ADDR_W'(16'h10c0),
        ADDR_W'(16'h1108), ADDR_W'(16'h1200), ADDR_W'(16'h1204)};
    // shadow of the force enable and forced values
    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            force_reg <= 1'b0;
            ovr_reg <= 3'h0;
        end else begin
            if (acc && PSTRB[1] && PADDR == ADDR_W'(16'h1078))
                force_reg <= PWDATA[8];
            if (acc && PSTRB[0] && PADDR == ADDR_W'(16'h10bc))
                ovr_reg <= PWDATA[2:0];
        end
    end
    default clocking @(posedge SYS_CLK); endclocking
    default disable iff (RST);
    sequence setup_s;
        PSEL && !PENABLE;
    endsequence
    sequence access_s;
        PSEL && PENABLE && PREADY;
    endsequence
    rdy_pulse_a: assert property (setup_s |=> access_s) else $error("no ready after setup");
    rdy_once_a: assert property (PREADY |=> !PREADY) else $error("ready longer than a cycle");
    bad_addr_a: assert property (setup_s |=> PSLVERR == !$past(mapped))
        else $error("error response wrong");
    upper_zero_a: assert property (PREADY |-> PRDATA[31:16] == 16'h0000)
        else $error("upper read data not zero");
    afe_follow_a: assert property (!$past(RST) |->
        {AFE_ENERGY_LOST, AFE_ENERGY_DET_EN, AFE_SLEEP_EN} == $past(sel))
        else $error("front-end control wrong");
    tx_write_a: assert property (acc && dly_hit && PSTRB[1]
        |=> TX_CLOCK_DELAY_CODE == $past(PWDATA[11:8])) else $error("tx code not written");
    rx_write_a: assert property (acc && dly_hit && PSTRB[0]
        |=> RX_CLOCK_DELAY_CODE == $past(PWDATA[7:4])) else $error("rx code not written");
    // a reset edge reloads the codes, so it is no hold cycle
    code_hold_a: assert property (!RST && !(acc && dly_hit)
        |=> $stable({TX_CLOCK_DELAY_CODE, RX_CLOCK_DELAY_CODE})) else $error("codes changed");
    rst_vals_a: assert property (disable iff (1'b0) RST |=> !PREADY && !IRQ
        && TX_CLOCK_DELAY_CODE == 4'h9 && RX_CLOCK_DELAY_CODE == 4'h6 && PRDATA == 32'h0)
        else $error("reset values wrong");
endmodule : aodr_chk

bind aodr_regs aodr_chk #(.ADDR_W(ADDR_W), .ESD_CNT_W(ESD_CNT_W)) u_chk (
    .SYS_CLK(SYS_CLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PADDR(PADDR), .PWDATA(PWDATA), .PSTRB(PSTRB), .PRDATA(PRDATA), .PREADY(PREADY),
    .PSLVERR(PSLVERR), .INT_SLEEP_EN(INT_SLEEP_EN), .INT_ENERGY_DET_EN(INT_ENERGY_DET_EN),
    .INT_ENERGY_LOST(INT_ENERGY_LOST), .AFE_SLEEP_EN(AFE_SLEEP_EN),
    .AFE_ENERGY_DET_EN(AFE_ENERGY_DET_EN), .AFE_ENERGY_LOST(AFE_ENERGY_LOST),
    .TX_CLOCK_DELAY_CODE(TX_CLOCK_DELAY_CODE), .RX_CLOCK_DELAY_CODE(RX_CLOCK_DELAY_CODE),
    .IRQ(IRQ));

// ### test/testbench.sv
// self-checking bench for the override and delay register bank
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int W = 2;
    localparam logic [15:0] A_FRC = 16'(aodr_pkg::IDX_FORCE_CTRL << 2);
    localparam logic [15:0] A_OVR = 16'(aodr_pkg::IDX_OVR << 2);
    localparam logic [15:0] A_DLY = 16'(aodr_pkg::IDX_DLY << 2);
    localparam logic [15:0] A_ESD = 16'(aodr_pkg::IDX_ESD << 2);
    localparam logic [15:0] A_ST = 16'(aodr_pkg::IDX_IRQ_STAT << 2);
    localparam logic [15:0] A_MSK = 16'(aodr_pkg::IDX_IRQ_MASK << 2);
    logic sys_clk, rst, psel, penable, pwrite, esd, pready, pslverr, irq, err;
    logic [15:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0] pstrb, tx, rx;
    logic [2:0] int_in, afe;
    int fails = 0;
    int tests_run = 0;
    int cyc = 0;
    aodr_regs #(.ADDR_W(16), .ESD_CNT_W(W)) u_dut (
        .SYS_CLK(sys_clk), .RST(rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
        .PADDR(paddr), .PWDATA(pwdata), .PSTRB(pstrb), .PRDATA(prdata), .PREADY(pready),
        .PSLVERR(pslverr), .INT_SLEEP_EN(int_in[0]), .INT_ENERGY_DET_EN(int_in[1]),
        .INT_ENERGY_LOST(int_in[2]), .AFE_SLEEP_EN(afe[0]), .AFE_ENERGY_DET_EN(afe[1]),
        .AFE_ENERGY_LOST(afe[2]), .TX_CLOCK_DELAY_CODE(tx), .RX_CLOCK_DELAY_CODE(rx),
        .ESD_EVENT(esd), .IRQ(irq));
    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : complete_run
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            fails++;
            complete_run();
        end
    end
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask : chk
    // one apb transfer, held until ready is sampled high
    task automatic xfer(input logic w, input logic [15:0] a, input logic [31:0] d,
        input logic [3:0] s);
        @(posedge sys_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge sys_clk);
        penable <= 1'b1;
        // if ready never comes, only the bench timeout ends this wait
        do begin
            @(posedge sys_clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : xfer
    task automatic wr(input logic [15:0] a, input logic [31:0] d);
        xfer(1'b1, a, d, 4'hf);
    endtask : wr
    task automatic rchk(input string name, input logic [15:0] a, input logic [31:0] exp);
        xfer(1'b0, a, 32'h0, 4'hf);
        chk(name, exp, rd);
    endtask : rchk
    task automatic afe_chk(input logic [2:0] exp);
        repeat (2) @(posedge sys_clk);
        chk("afe", {29'h0, exp}, {29'h0, afe});
    endtask : afe_chk
    task automatic pulse();
        @(posedge sys_clk);
        esd <= 1'b1;
        @(posedge sys_clk);
        esd <= 1'b0;
    endtask : pulse
    initial begin
        {rst, psel, penable, pwrite, esd} = 5'h10;
        paddr = 16'h0;
        pwdata = 32'h0;
        pstrb = 4'h0;
        int_in = 3'h0;
        repeat (20) @(posedge sys_clk);
        rst <= 1'b0;
        rchk("ovr", A_OVR, 32'h0);
        rchk("dly", A_DLY, 32'h0960);
        rchk("esd", A_ESD, 32'h0);
        chk("tx", 32'h9, {28'h0, tx});
        chk("rx", 32'h6, {28'h0, rx});
        wr(A_OVR, 32'hffff_ffff);
        rchk("ovr", A_OVR, 32'h7);
        wr(A_DLY, 32'hffff_ffff);
        rchk("dly", A_DLY, 32'h0ff0);
        wr(A_DLY, 32'h0000_0a50);
        rchk("dly", A_DLY, 32'h0a50);
        chk("tx", 32'ha, {28'h0, tx});
        chk("rx", 32'h5, {28'h0, rx});
        xfer(1'b1, A_DLY, 32'h0, 4'h1);
        rchk("dly", A_DLY, 32'h0a00);
        wr(A_ESD, 32'hffff_ffff);
        rchk("esd", A_ESD, 32'h0);
        int_in <= 3'b101;
        wr(A_OVR, 32'h2);
        afe_chk(3'b101);
        wr(A_FRC, 32'h0100);
        afe_chk(3'b010);
        int_in <= 3'b010;
        wr(A_OVR, 32'h5);
        afe_chk(3'b101);
        wr(A_FRC, 32'h0);
        afe_chk(3'b010);
        pulse();
        rchk("esd", A_ESD, 32'h0200);
        chk("irq", 32'h0, {31'h0, irq});
        wr(A_MSK, 32'h3);
        rchk("stat", A_ST, 32'h1);
        chk("irq", 32'h1, {31'h0, irq});
        wr(A_ST, 32'h1);
        rchk("stat", A_ST, 32'h0);
        chk("irq", 32'h0, {31'h0, irq});
        repeat (4) pulse();
        rchk("esd", A_ESD, 32'((2 ** W - 1) << 9));
        rchk("stat", A_ST, 32'h3);
        wr(A_ST, 32'h3);
        pulse();
        rchk("stat", A_ST, 32'h0);
        xfer(1'b0, 16'h1000, 32'h0, 4'hf);
        chk("err", 32'h1, {31'h0, err});
        chk("bad", 32'h0, rd);
        @(posedge sys_clk);
        rst <= 1'b1;
        @(posedge sys_clk);
        rst <= 1'b0;
        rchk("esd", A_ESD, 32'h0);
        rchk("dly", A_DLY, 32'h0960);
        complete_run();
    end
endmodule : testbench
